// file: design/gpio_gh_pkg.sv
`default_nettype none
package gpio_gh_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_G_LATCH  = 6'h10;
  localparam logic [5:0] IDX_G_LEVEL  = 6'h11;
  localparam logic [5:0] IDX_G_DIR    = 6'h12;
  localparam logic [5:0] IDX_G_REDUCE = 6'h13;
  localparam logic [5:0] IDX_G_PULL   = 6'h14;
  localparam logic [5:0] IDX_G_POL    = 6'h15;
  localparam logic [5:0] IDX_G_IRQEN  = 6'h16;
  localparam logic [5:0] IDX_G_FLAGS  = 6'h17;
  localparam logic [5:0] IDX_H_LATCH  = 6'h18;
  localparam logic [5:0] IDX_H_LEVEL  = 6'h19;
  localparam logic [5:0] IDX_H_DIR    = 6'h1A;

  ////////////////////////////////////////////////////////////////////////
  // Widths, masks and reset values
  localparam int          PORT_W     = 8;
  localparam int          MII_W      = 7;
  localparam int          ADR_LSB    = 2;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [7:0]  H_IMPL     = 8'h7F;
  localparam logic [7:0]  G_MII_PINS = 8'h7F;
  localparam logic [23:0] RD_UPPER   = 24'h000000;

  ////////////////////////////////////////////////////////////////////////
  // Register groups
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] reduce;
    logic [7:0] pull_en;
    logic [7:0] polarity;
    logic [7:0] irq_en;
    logic [7:0] flags;
  } port_g_regs_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
  } port_h_regs_t;

endpackage
`default_nettype wire

// file: design/gpio_gh.sv
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module gpio_gh
  import gpio_gh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        mii_ext_en_i,
  input  wire logic [7:0]  g_pin_i,
  output logic      [7:0]  g_pin_o,
  output logic      [7:0]  g_pin_oe_o,
  output logic      [7:0]  g_reduce_o,
  output logic      [7:0]  g_pull_en_o,
  output logic      [7:0]  g_pull_down_o,
  input  wire logic [7:0]  h_pin_i,
  output logic      [7:0]  h_pin_o,
  output logic      [7:0]  h_pin_oe_o,
  output logic      [6:0]  mii_rx_o,
  input  wire logic [6:0]  mii_tx_i,
  input  wire logic [6:0]  mii_tx_oe_i,
  output logic      [6:0]  mii_h_level_o
);

  ////////////////////////////////////////////////////////////////////////
  // State
  port_g_regs_t g_r;
  port_g_regs_t g_nxt;
  port_h_regs_t h_r;
  port_h_regs_t h_nxt;
  logic [7:0]   g_s1_r;
  logic [7:0]   g_s2_r;
  logic [7:0]   g_s3_r;
  logic [7:0]   h_s1_r;
  logic [7:0]   h_s2_r;
  logic         ack_r;
  logic [7:0]   rdat_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic [5:0] idx;
  wire logic       req;
  wire logic       wr;
  wire logic [7:0] wdat;
  wire logic [7:0] g_ev;
  wire logic [7:0] g_dir_eff;
  wire logic [7:0] h_dir_eff;
  wire logic [7:0] g_rd_io;
  wire logic [7:0] h_rd_io;
  wire logic [7:0] rd_mux;

  assign idx  = adr_i[7:ADR_LSB];
  assign req  = cyc_i & stb_i;
  assign wr   = req & we_i & ack_r & sel_i[0];
  assign wdat = dat_i[7:0];

  function automatic logic wr_hit(input logic [5:0] a,
                                  input logic [5:0] r);
    wr_hit = (a == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write strobes
  wire logic wr_g_latch;
  wire logic wr_g_dir;
  wire logic wr_g_reduce;
  wire logic wr_g_pull;
  wire logic wr_g_pol;
  wire logic wr_g_irqen;
  wire logic wr_g_flags;
  wire logic wr_h_latch;
  wire logic wr_h_dir;

  assign wr_g_latch  = wr & wr_hit(idx, IDX_G_LATCH);
  assign wr_g_dir    = wr & wr_hit(idx, IDX_G_DIR);
  assign wr_g_reduce = wr & wr_hit(idx, IDX_G_REDUCE);
  assign wr_g_pull   = wr & wr_hit(idx, IDX_G_PULL);
  assign wr_g_pol    = wr & wr_hit(idx, IDX_G_POL);
  assign wr_g_irqen  = wr & wr_hit(idx, IDX_G_IRQEN);
  assign wr_g_flags  = wr & wr_hit(idx, IDX_G_FLAGS);
  assign wr_h_latch  = wr & wr_hit(idx, IDX_H_LATCH);
  assign wr_h_dir    = wr & wr_hit(idx, IDX_H_DIR);

  ////////////////////////////////////////////////////////////////////////
  // Effective direction
  assign g_dir_eff = mii_ext_en_i ? (g_r.dir & ~G_MII_PINS)
                                  : g_r.dir;
  assign h_dir_eff = mii_ext_en_i
                   ? {1'b0, mii_tx_oe_i}
                   : (h_r.dir & H_IMPL);

  ////////////////////////////////////////////////////////////////////////
  // Pad controls
  assign g_pin_o       = g_r.latch;
  assign g_pin_oe_o    = g_dir_eff;
  assign g_reduce_o    = g_r.reduce & g_dir_eff;
  assign g_pull_en_o   = g_r.pull_en & ~g_dir_eff;
  assign g_pull_down_o = g_r.polarity;
  assign h_pin_o       = mii_ext_en_i
                       ? {1'b0, mii_tx_i}
                       : (h_r.latch & H_IMPL);
  assign h_pin_oe_o    = h_dir_eff;
  assign mii_rx_o      = mii_ext_en_i ? g_s2_r[6:0] : 7'h00;
  assign mii_h_level_o = h_s2_r[6:0];

  ////////////////////////////////////////////////////////////////////////
  // Readback
  assign g_rd_io = (g_r.latch & g_dir_eff)
                 | (g_s2_r & ~g_dir_eff);
  assign h_rd_io = ((h_r.latch & h_dir_eff)
                 | (h_s2_r & ~h_dir_eff)) & H_IMPL;

  function automatic logic [7:0] rd_sel(
    input logic [5:0]   a,
    input port_g_regs_t g,
    input port_h_regs_t h,
    input logic [7:0]   g_io,
    input logic [7:0]   g_lv,
    input logic [7:0]   h_io,
    input logic [7:0]   h_lv
  );
    case (a)
      IDX_G_LATCH:  rd_sel = g_io;
      IDX_G_LEVEL:  rd_sel = g_lv;
      IDX_G_DIR:    rd_sel = g.dir;
      IDX_G_REDUCE: rd_sel = g.reduce;
      IDX_G_PULL:   rd_sel = g.pull_en;
      IDX_G_POL:    rd_sel = g.polarity;
      IDX_G_IRQEN:  rd_sel = g.irq_en;
      IDX_G_FLAGS:  rd_sel = g.flags;
      IDX_H_LATCH:  rd_sel = h_io;
      IDX_H_LEVEL:  rd_sel = h_lv;
      IDX_H_DIR:    rd_sel = h.dir & H_IMPL;
      default:      rd_sel = REG_RST;
    endcase
  endfunction

  assign rd_mux = rd_sel(idx, g_r, h_r, g_rd_io, g_s2_r,
                         h_rd_io, h_s2_r);

  ////////////////////////////////////////////////////////////////////////
  // Edge detection per pin
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_edge
      assign g_ev[gi] = g_r.polarity[gi]
                      ? ( g_s2_r[gi] & ~g_s3_r[gi])
                      : (~g_s2_r[gi] &  g_s3_r[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next register values
  always_comb begin
    g_nxt = g_r;
    h_nxt = h_r;
    if (wr_g_latch)
      g_nxt.latch = wdat;
    if (wr_g_dir)
      g_nxt.dir = wdat;
    if (wr_g_reduce)
      g_nxt.reduce = wdat;
    if (wr_g_pull)
      g_nxt.pull_en = wdat;
    if (wr_g_pol)
      g_nxt.polarity = wdat;
    if (wr_g_irqen)
      g_nxt.irq_en = wdat;
    if (wr_g_flags)
      g_nxt.flags = g_r.flags & ~wdat;
    g_nxt.flags = g_nxt.flags | g_ev;
    if (wr_h_latch)
      h_nxt.latch = wdat & H_IMPL;
    if (wr_h_dir)
      h_nxt.dir = wdat & H_IMPL;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      g_r <= '{default: REG_RST};
      h_r <= '{default: REG_RST};
    end else begin
      g_r <= g_nxt;
      h_r <= h_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      g_s1_r <= REG_RST;
      g_s2_r <= REG_RST;
      g_s3_r <= REG_RST;
      h_s1_r <= REG_RST;
      h_s2_r <= REG_RST;
    end else begin
      g_s1_r <= g_pin_i;
      g_s2_r <= g_s1_r;
      g_s3_r <= g_s2_r;
      h_s1_r <= h_pin_i;
      h_s2_r <= h_s1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= REG_RST;
    end else begin
      ack_r  <= req & ~ack_r;
      rdat_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus and interrupt outputs
  assign ack_o = ack_r & req;
  assign dat_o = {RD_UPPER, rdat_r};
  assign irq_o = |(g_r.flags & g_r.irq_en);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_after_req:
    assert property (req && !ack_r |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single:
    assert property (ack_o |=> !ack_r)
    else $error("ack held for two cycles");
  a_mii_g_input:
    assert property (mii_ext_en_i |-> (g_pin_oe_o & G_MII_PINS) == 8'h00)
    else $error("group g mii pins not forced to input");
  a_g_dir_control:
    assert property (!mii_ext_en_i |-> g_pin_oe_o == g_r.dir)
    else $error("group g direction not following register");
  a_h_mii_own:
    assert property (mii_ext_en_i |-> h_pin_oe_o[6:0] == mii_tx_oe_i
                     && h_pin_o[6:0] == mii_tx_i)
    else $error("group h pins not owned by mii");
  a_edge_sets_flag:
    assert property (g_ev != 8'h00 |=> (g_r.flags & $past(g_ev))
                     == $past(g_ev))
    else $error("active edge did not set flag");
  a_flag_w1c:
    assert property (wr && idx == IDX_G_FLAGS |=> g_r.flags ==
                     (($past(g_r.flags) & ~$past(wdat)) | $past(g_ev)))
    else $error("flag clear by write one misbehaves");
  a_irq_on_edge:
    assert property ((g_ev & g_r.irq_en) != 8'h00 && !wr_g_irqen |=> irq_o)
    else $error("enabled edge did not raise interrupt");
  a_masked_quiet:
    assert property (g_r.irq_en == 8'h00 |-> !irq_o)
    else $error("interrupt with all enables clear");
  a_pin_level_read:
    assert property (ack_o && !we_i && idx == IDX_G_LEVEL
                     |-> dat_o[7:0] == $past(g_s2_r))
    else $error("pin level readback wrong");
  a_reduce_output:
    assert property ((g_reduce_o & ~g_pin_oe_o) == 8'h00)
    else $error("reduced drive on an input pin");
  a_pull_input:
    assert property ((g_pull_en_o & g_pin_oe_o) == 8'h00)
    else $error("pull device on an output pin");
  a_h_bit7_zero:
    assert property (ack_o && !we_i && (idx == IDX_H_DIR ||
                     idx == IDX_H_LATCH) |-> !dat_o[7])
    else $error("group h bit 7 not reading zero");
  a_pin_sync_lag:
    assert property (!mii_ext_en_i && !g_r.dir[7] ##1 !g_r.dir[7] ##1
                     !g_r.dir[7] |-> g_rd_io[7] == $past(g_pin_i[7], 2))
    else $error("input readback lag not two cycles");

  a_read_latch:
    assert property (ack_o && !we_i && idx == IDX_G_LATCH
                     |-> dat_o[7:0] == $past(g_rd_io))
    else $error("output register readback wrong");

  a_write_latch:
    assert property (wr_g_latch |=> g_r.latch == $past(wdat))
    else $error("output latch write lost");

  a_write_dir:
    assert property (wr_g_dir |=> g_r.dir == $past(wdat))
    else $error("direction write lost");

  a_level_read_only:
    assert property (wr && idx == IDX_G_LEVEL |=> g_r.latch ==
                     $past(g_r.latch) && g_r.dir == $past(g_r.dir))
    else $error("write to pin level register changed state");

  a_h_level_read:
    assert property (ack_o && !we_i && idx == IDX_H_LEVEL
                     |-> dat_o[7:0] == $past(h_s2_r))
    else $error("group h pin level readback wrong");

  a_flag_sticky:
    assert property (!wr_g_flags |=> ($past(g_r.flags) & ~g_r.flags)
                     == 8'h00)
    else $error("flag cleared without a write");

  a_flag_holds:
    assert property (g_ev == 8'h00 && !wr_g_flags
                     |=> g_r.flags == $past(g_r.flags))
    else $error("flag set without an active edge");

  a_reset_quiet:
    assert property ($past(rst_i) |-> g_pull_en_o == 8'h00
                     && g_pin_oe_o == 8'h00 && !irq_o)
    else $error("outputs not quiet after reset");

  a_mii_rx_lag:
    assert property (mii_ext_en_i && !$past(rst_i) && !$past(rst_i, 2)
                     |-> mii_rx_o == $past(g_pin_i[6:0], 2))
    else $error("mii receive signals not synchronised");

  a_h_pin7_idle:
    assert property (!h_pin_oe_o[7] && !h_pin_o[7])
    else $error("group h bit 7 driven");

  a_h_gpio_dir:
    assert property (!mii_ext_en_i |-> h_pin_oe_o == h_r.dir)
    else $error("group h direction not following register");

  a_h_write_mask:
    assert property (wr_h_dir |=> h_r.dir == ($past(wdat) & H_IMPL))
    else $error("group h direction bit 7 stored");

  c_edge_irq:
    cover property ((g_ev & g_r.irq_en) != 8'h00 ##1 irq_o);
  c_flag_clear:
    cover property (wr && idx == IDX_G_FLAGS && wdat != 8'h00);
  c_mii_mode:
    cover property (!mii_ext_en_i ##1 mii_ext_en_i);
  c_read_ack:
    cover property (ack_o && !we_i && idx == IDX_G_LATCH);
  c_flag_keep:
    cover property (wr_g_flags && wdat == 8'h00);

endmodule
`default_nettype wire

// file: sim/gpio_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] g_o_i,
  input  wire logic [7:0] g_oe_i,
  input  wire logic [7:0] g_pe_i,
  input  wire logic [7:0] g_pd_i,
  input  wire logic [7:0] h_o_i,
  input  wire logic [7:0] h_oe_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] g_ext_i,
  input  wire logic [7:0] h_ext_i,
  output logic      [7:0] g_pin_o,
  output logic      [7:0] h_pin_o
);
  logic       flip_r;
  logic [7:0] g_free;
  initial flip_r = 1'b0;
  always @(posedge clk_i) begin
    flip_r <= ~flip_r;
  end
  // Undriven pad: pull level, else a changing pattern
  assign g_free = (g_pe_i & ~g_pd_i) | (~g_pe_i & {8{flip_r}});
  assign g_pin_o = (g_oe_i & g_o_i) | (~g_oe_i & ext_en_i & g_ext_i)
                 | (~g_oe_i & ~ext_en_i & g_free);
  assign h_pin_o = (h_oe_i & h_o_i) | (~h_oe_i & h_ext_i);
endmodule
`default_nettype wire

// file: sim/gpio_gh_tb.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_gh_tb;
  import gpio_gh_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, mii_en;
  logic [7:0]  adr_i, g_pin_i, g_pin_o, g_oe, g_red, g_pe, g_pd;
  logic [7:0]  h_pin_i, h_pin_o, h_oe, ext_en, g_ext, h_ext;
  logic [7:0]  l, d, r, pe, p, e, f, x;
  logic [6:0]  mii_rx, mii_tx, mii_tx_oe, mii_h_lv;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  int          n_errors, comparisons, seed;

  gpio_gh i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .mii_ext_en_i(mii_en), .g_pin_i(g_pin_i), .g_pin_o(g_pin_o),
    .g_pin_oe_o(g_oe), .g_reduce_o(g_red), .g_pull_en_o(g_pe),
    .g_pull_down_o(g_pd), .h_pin_i(h_pin_i), .h_pin_o(h_pin_o),
    .h_pin_oe_o(h_oe), .mii_rx_o(mii_rx), .mii_tx_i(mii_tx),
    .mii_tx_oe_i(mii_tx_oe), .mii_h_level_o(mii_h_lv));
  gpio_pad_model i_pads (.clk_i(clk_i), .g_o_i(g_pin_o), .g_oe_i(g_oe),
    .g_pe_i(g_pe), .g_pd_i(g_pd), .h_o_i(h_pin_o), .h_oe_i(h_oe),
    .ext_en_i(ext_en), .g_ext_i(g_ext), .h_ext_i(h_ext),
    .g_pin_o(g_pin_i), .h_pin_o(h_pin_i));

  ////////////////////////////////////////////////////////////////////////
  // Expectations and bus cycles
  function automatic logic [7:0] rb(logic [7:0] lt, dr, pn);
    return (lt & dr) | (pn & ~dr);
  endfunction
  function automatic logic [7:0] edg(logic [7:0] a, b, pol);
    return (~a & b & pol) | (a & ~b & ~pol);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] v);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h000000, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) n_errors++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] i, input logic [7:0] v);
    wb(1'b0, i, 8'h00);
    chk(q, {24'h000000, v});
  endtask
  task automatic print_verdict;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and tests
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict;
  end
  initial begin
    seed = 2;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, mii_en} = 4'h0;
    {adr_i, dat_i, g_ext, h_ext} = '0;
    {mii_tx, mii_tx_oe} = '0;
    sel_i = 4'hF;
    ext_en = 8'hFF;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 16; i < 27; i++) rc(6'(i), 8'h00);
    rc(6'h3F, 8'h00);
    chk(irq_o, 1'b0);
    $display("test reset done");
    repeat (8) begin
      {l, d, r, pe} = $random(seed);
      p = 8'($random(seed));
      g_ext <= 8'($random(seed));
      h_ext <= 8'($random(seed));
      ext_en <= ~pe;
      wb(1'b1, IDX_G_LATCH, l);
      wb(1'b1, IDX_G_DIR, d);
      wb(1'b1, IDX_G_REDUCE, r);
      wb(1'b1, IDX_G_PULL, pe);
      wb(1'b1, IDX_G_POL, p);
      wb(1'b1, IDX_H_LATCH, l);
      wb(1'b1, IDX_H_DIR, d);
      repeat (3) @(posedge clk_i);
      x = (d & l) | (~d & pe & ~p) | (~d & ~pe & g_ext);
      rc(IDX_G_LATCH, rb(l, d, x));
      wb(1'b1, IDX_G_LEVEL, ~x);
      rc(IDX_G_LEVEL, x);
      rc(IDX_H_LATCH, rb(l, d, h_ext) & H_IMPL);
      rc(IDX_H_LEVEL, rb(l, d & H_IMPL, h_ext));
      rc(IDX_H_DIR, d & H_IMPL);
      chk(g_oe, d);
      chk(g_red, r & d);
      chk(g_pe, pe & ~d);
      chk(g_pd, p);
      chk(h_oe, d & H_IMPL);
    end
    $display("test registers done");
    ext_en <= 8'hFF;
    wb(1'b1, IDX_G_DIR, 8'h00);
    wb(1'b1, IDX_G_PULL, 8'h00);
    repeat (4) @(posedge clk_i);
    repeat (8) begin
      {p, e, x, l} = $random(seed);
      wb(1'b1, IDX_G_FLAGS, 8'hFF);
      wb(1'b1, IDX_G_POL, p);
      wb(1'b1, IDX_G_IRQEN, e);
      f = edg(g_ext, x, p);
      g_ext <= x;
      repeat (5) @(posedge clk_i);
      rc(IDX_G_FLAGS, f);
      chk(irq_o, |(f & e));
      wb(1'b1, IDX_G_FLAGS, 8'h00);
      rc(IDX_G_FLAGS, f);
      wb(1'b1, IDX_G_FLAGS, f & 8'h0F);
      rc(IDX_G_FLAGS, f & 8'hF0);
    end
    $display("test edges done");
    mii_tx <= 7'($random(seed));
    mii_tx_oe <= 7'($random(seed));
    mii_en <= 1'b1;
    wb(1'b1, IDX_G_DIR, 8'hFF);
    wb(1'b1, IDX_G_LATCH, l);
    repeat (3) @(posedge clk_i);
    chk(g_oe, 8'h80);
    chk(g_pin_o, l);
    rc(IDX_G_LATCH, rb(l, 8'h80, g_ext));
    chk(mii_rx, g_ext[6:0]);
    chk(h_pin_o, {1'b0, mii_tx});
    chk(h_oe, {1'b0, mii_tx_oe});
    chk(mii_h_lv, (mii_tx_oe & mii_tx) | (~mii_tx_oe & h_ext[6:0]));
    mii_en <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(g_oe, 8'hFF);
    chk(mii_rx, 7'h00);
    sel_i <= 4'hE;
    wb(1'b1, IDX_G_DIR, 8'h00);
    sel_i <= 4'hF;
    rc(IDX_G_DIR, 8'hFF);
    $display("test mii done");
    print_verdict;
  end
endmodule
`default_nettype wire
